/* File: sdi_parallel_video_input_port_test.sv */
// Self-checking bench joining the video source end and the input port end
`timescale 1ns/100ps
`include "svip_consts.svh"
module sdi_parallel_video_input_port_test;
  logic SYS_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [2:0] MODE;
  logic [`SVIP_WORD_W-1:0] LUMA, CHROMA, RAW, Y_WORD, C_WORD, RAW_WORD;
  logic WORD_VALID, ASI_VALID, FIELD2, VBLANK, HBLANK, DATA_ENABLE, HSYNC, VSYNC, TIMING_VALID;
  logic [17:0] tv;
  int mq[$];
  int m, c, me;
  logic [17:0] PCLK_KHZ;
  logic BUS_WIDTH_SELECT, VIDEO_PROCESSING_SELECT, TRANSPORT_MODE_SELECT, STREAM_TIMING_DETECT;
  logic SYNC_FORM, H_TRS_FORM, PROCESSING_FEATURES_ENABLE, IN_HBLANK, IN_VBLANK, IN_FIELD2;
  logic PROGRESSIVE, HSYNC_REQ, VSYNC_REQ;
  int num_errors = 0, num_checks = 0, cycles = 0, w, t, d;
  svip_if lk ();
  svip_source svip_source_i (.SYS_CLK, .RST_N, .link(lk), .BUS_WIDE(BUS_WIDTH_SELECT),
    .SMPTE_ON(VIDEO_PROCESSING_SELECT), .ASI_ON(TRANSPORT_MODE_SELECT), .SYNC_FORM,
    .H_TRS_FORM, .Y_WORD, .C_WORD, .RAW_WORD, .IN_HBLANK, .IN_VBLANK, .IN_FIELD2,
    .PROGRESSIVE, .HSYNC_REQ, .VSYNC_REQ, .CHROMA_NEXT());
  svip_port svip_port_i (.SYS_CLK, .RST_N, .link(lk), .BUS_WIDTH_SELECT,
    .VIDEO_PROCESSING_SELECT, .TRANSPORT_MODE_SELECT, .STREAM_TIMING_DETECT,
    .SYNC_TIMING_FORM_SELECT(SYNC_FORM), .PROCESSING_FEATURES_ENABLE, .MODE, .LUMA, .CHROMA,
    .RAW, .WORD_VALID, .ASI_VALID, .FIELD2, .VBLANK, .HBLANK, .DATA_ENABLE, .HSYNC, .VSYNC,
    .TIMING_VALID, .PCLK_KHZ);
  svip_properties svip_properties_i (.SYS_CLK, .RST_N, .din(lk.din),
    .field_or_enable_in(lk.field_or_enable_in), .vert_or_vsync(lk.vert_or_vsync),
    .horiz_or_hsync(lk.horiz_or_hsync), .SYNC_FORM, .IN_HBLANK, .IN_VBLANK, .IN_FIELD2,
    .PROGRESSIVE, .BUS_WIDTH_SELECT, .VIDEO_PROCESSING_SELECT, .TRANSPORT_MODE_SELECT,
    .STREAM_TIMING_DETECT, .MODE, .LUMA, .RAW, .WORD_VALID, .HBLANK, .VBLANK, .TIMING_VALID);
  always #4 SYS_CLK = ~SYS_CLK;
  task finish_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(string n, int e, logic [17:0] g);
    num_checks++;
    if (g !== 18'(e)) begin
      num_errors++;
      $display("unexpected %s: expected %0h seen %0h", n, e, g);
    end
  endtask
  // Whole configuration changes at once so every mode meets every timing form
  task drive();
    {BUS_WIDTH_SELECT, VIDEO_PROCESSING_SELECT, TRANSPORT_MODE_SELECT, STREAM_TIMING_DETECT,
      SYNC_FORM, H_TRS_FORM, PROCESSING_FEATURES_ENABLE, IN_HBLANK, IN_VBLANK, IN_FIELD2,
      PROGRESSIVE, HSYNC_REQ, VSYNC_REQ} = 13'($urandom);
    {Y_WORD, C_WORD, RAW_WORD} = 30'($urandom);
  endtask
  // Timing reference: outputs after an edge reflect pins taken two edges earlier
  always @(posedge SYS_CLK) begin
    if (RST_N) begin
      mq.push_back(int'({STREAM_TIMING_DETECT, SYNC_FORM, VSYNC_REQ, HSYNC_REQ, PROGRESSIVE,
        IN_FIELD2, IN_VBLANK, IN_HBLANK}));
    end
  end
  always @(negedge SYS_CLK) begin
    if (mq.size() == 3) begin
      m = mq.pop_front();
      c = mq[1];
      me = 0;
      if (!c[7]) begin
        me = int'({1'b1, !m[0] && !m[1], !c[6] && m[2] && !m[3], !c[6] && m[1],
          !c[6] && m[0], c[6] && m[4], c[6] && m[5]});
      end
      tv = {11'h0, TIMING_VALID, DATA_ENABLE, FIELD2, VBLANK, HBLANK, HSYNC, VSYNC};
      // A form or detect change inside the window leaves the pins ambiguous
      if (m[7:6] == c[7:6]) begin
        chk("timing", me, tv);
      end
    end
  end
  always @(posedge SYS_CLK) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(4978));
    drive();
    repeat (2) @(negedge SYS_CLK);
    RST_N = 1'b1;
    for (int i = 0; i < 48; i++) begin
      drive();
      repeat (8) @(negedge SYS_CLK);
      w = BUS_WIDTH_SELECT;
      t = !w && !VIDEO_PROCESSING_SELECT && TRANSPORT_MODE_SELECT;
      d = STREAM_TIMING_DETECT;
      if (VIDEO_PROCESSING_SELECT) begin
        chk("luma", Y_WORD, LUMA);
        chk("chroma", C_WORD, CHROMA);
      end else begin
        chk("raw", RAW_WORD, RAW);
      end
      if (!d) chk("mode", VIDEO_PROCESSING_SELECT ? !w : 2 + t, MODE);
      chk("valid", !d, TIMING_VALID);
      chk("asi", t, ASI_VALID);
      chk("enable", !IN_HBLANK && !IN_VBLANK && !d, DATA_ENABLE);
      if (SYNC_FORM) begin
        chk("hsync", HSYNC_REQ && !d, HSYNC);
        chk("vsync", VSYNC_REQ && !d, VSYNC);
      end else begin
        chk("hblank", IN_HBLANK && !d, HBLANK);
        chk("vblank", IN_VBLANK && !d, VBLANK);
        chk("field", IN_FIELD2 && !PROGRESSIVE && !d, FIELD2);
      end
      chk("pclk", w ? (PROCESSING_FEATURES_ENABLE ? 18'h1220a : 18'h034bc)
        : (PROCESSING_FEATURES_ENABLE && !t ? 18'h24414 : 18'h06978), PCLK_KHZ);
      $display("test %0d done", i);
    end
    finish_test();
  end
endmodule

/* File: svip_consts.svh */
// Constants for the parallel video input port: bus layout and clock rates
`ifndef SVIP_CONSTS_SVH
`define SVIP_CONSTS_SVH
`define SVIP_BUS_W 20
`define SVIP_WORD_W 10
`define SVIP_HI_LSB 10
`define SVIP_SYS_CLK_KHZ 125000
`define SVIP_PCLK_HD_WIDE_KHZ 74250
`define SVIP_PCLK_HD_NARROW_KHZ 148500
`define SVIP_PCLK_SD_WIDE_KHZ 13500
`define SVIP_PCLK_SD_NARROW_KHZ 27000
`define SVIP_PCLK_ASI_KHZ 27000
`define SVIP_MODE_RESET 1'b0
`endif

/* File: svip_demux.sv */
// Splits the narrow interleaved bus into chroma and luma words
`timescale 1ns/100ps
`include "svip_consts.svh"
module svip_demux (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic enable,
  input wire logic [`SVIP_WORD_W-1:0] word,
  output logic [`SVIP_WORD_W-1:0] chroma,
  output logic [`SVIP_WORD_W-1:0] luma,
  output logic pair_valid
);
  svip_pkg::svip_phase_e phase;
  svip_pkg::svip_phase_e next_phase;
  logic [`SVIP_WORD_W-1:0] next_chroma;
  logic [`SVIP_WORD_W-1:0] next_luma;
  logic next_pair_valid;

  always_comb begin
    next_phase = phase;
    next_chroma = chroma;
    next_luma = luma;
    next_pair_valid = 1'b0;
    if (!enable) begin
      next_phase = svip_pkg::SVIP_PHASE_CHROMA;
    end else begin
      unique case (phase)
        svip_pkg::SVIP_PHASE_CHROMA: begin
          next_chroma = word; // [RULE2]
          next_phase = svip_pkg::SVIP_PHASE_LUMA;
        end
        svip_pkg::SVIP_PHASE_LUMA: begin
          next_luma = word; // [RULE2]
          next_pair_valid = 1'b1;
          next_phase = svip_pkg::SVIP_PHASE_CHROMA;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      phase <= svip_pkg::SVIP_PHASE_CHROMA;
      chroma <= '0;
      luma <= '0;
      pair_valid <= 1'b0;
    end else begin
      phase <= next_phase;
      chroma <= next_chroma;
      luma <= next_luma;
      pair_valid <= next_pair_valid;
    end
  end
endmodule

/* File: svip_if.sv */
// Parallel bus and timing pins between a video source and the input port
`timescale 1ns/100ps
`include "svip_consts.svh"
interface svip_if;
  logic [`SVIP_BUS_W-1:0] din;
  logic field_or_enable_in;
  logic vert_or_vsync;
  logic horiz_or_hsync;
  modport source (output din, output field_or_enable_in, output vert_or_vsync,
    output horiz_or_hsync);
  modport device (input din, input field_or_enable_in, input vert_or_vsync,
    input horiz_or_hsync);
endinterface

/* File: svip_pkg.sv */
// Types used by the device end (port and demux) of the parallel video input port
package svip_pkg;
  typedef enum logic [2:0] {
    SVIP_MODE_LUMA_WIDE,
    SVIP_MODE_MUX_NARROW,
    SVIP_MODE_RAW,
    SVIP_MODE_ASI,
    SVIP_MODE_STREAM_TIMING
  } svip_mode_e;
  typedef enum logic [1:0] {
    SVIP_PHASE_CHROMA,
    SVIP_PHASE_LUMA
  } svip_phase_e;
endpackage

/* File: svip_port.sv */
// Device end: samples the parallel bus and timing and classifies each word
//
// Notes on behaviour
// [RULE1] Wide SMPTE: upper ten inputs are luma
// [RULE2] Narrow SMPTE: luma and chroma interleaved, demultiplexed
// [RULE3] Bypass: upper ten inputs are raw data
// [RULE4] Narrow bypass with ASI: transport data
// [RULE5] Field flag high in field two only
// [RULE6] Sync form: enable high in active pixels
// [RULE7] Active-line H: low across active pixels only
// [RULE8] Default H: high across blanking incl. TRS
// [RULE9] H config one: H follows TRS H bit; the source drives H from IN_HBLANK whatever H_TRS_FORM is
// [RULE10] Stream detect: all timing inputs ignored
// [RULE11] Vertical flag high through vertical blanking
// [RULE12] Parallel clock rates per width and standard
// [RULE13] Bus and timing sampled on one edge
`timescale 1ns/100ps
`include "svip_consts.svh"
module svip_port (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  svip_if.device link,
  input wire logic BUS_WIDTH_SELECT,
  input wire logic VIDEO_PROCESSING_SELECT,
  input wire logic TRANSPORT_MODE_SELECT,
  input wire logic STREAM_TIMING_DETECT,
  input wire logic SYNC_TIMING_FORM_SELECT,
  input wire logic PROCESSING_FEATURES_ENABLE,
  output logic [2:0] MODE,
  output logic [`SVIP_WORD_W-1:0] LUMA,
  output logic [`SVIP_WORD_W-1:0] CHROMA,
  output logic [`SVIP_WORD_W-1:0] RAW,
  output logic WORD_VALID,
  output logic ASI_VALID,
  output logic FIELD2,
  output logic VBLANK,
  output logic HBLANK,
  output logic DATA_ENABLE,
  output logic HSYNC,
  output logic VSYNC,
  output logic TIMING_VALID,
  output logic [17:0] PCLK_KHZ
);
  // One registered snapshot so data and timing stay aligned word by word
  logic [`SVIP_BUS_W-1:0] din_s;
  logic f_s;
  logic v_s;
  logic h_s;
  svip_pkg::svip_mode_e mode;
  svip_pkg::svip_mode_e next_mode;
  logic [`SVIP_WORD_W-1:0] dm_chroma;
  logic [`SVIP_WORD_W-1:0] dm_luma;
  logic dm_valid;
  logic [`SVIP_WORD_W-1:0] next_luma;
  logic [`SVIP_WORD_W-1:0] next_chroma;
  logic [`SVIP_WORD_W-1:0] next_raw;
  logic next_word_valid;
  logic next_asi_valid;
  logic next_field2;
  logic next_vblank;
  logic next_hblank;
  logic next_de;
  logic next_hsync;
  logic next_vsync;
  logic next_timing_valid;
  logic [17:0] next_pclk;
  logic [`SVIP_WORD_W-1:0] hi_word;
  // Demux enable trails the mode by one edge, matching the source register plus snapshot
  logic mux_en;
  logic next_mux_en;

  assign hi_word = din_s[`SVIP_BUS_W-1:`SVIP_HI_LSB];

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      din_s <= '0;
      f_s <= 1'b0;
      v_s <= 1'b0;
      h_s <= 1'b0;
    end else begin
      din_s <= link.din; // [RULE13]
      f_s <= link.field_or_enable_in; // [RULE13]
      v_s <= link.vert_or_vsync;
      h_s <= link.horiz_or_hsync;
    end
  end

  svip_demux u_demux (
    .SYS_CLK(SYS_CLK),
    .RST_N(RST_N),
    .enable(mux_en),
    .word(hi_word),
    .chroma(dm_chroma),
    .luma(dm_luma),
    .pair_valid(dm_valid)
  );

  always_comb begin
    next_mux_en = (mode == svip_pkg::SVIP_MODE_MUX_NARROW); // [RULE2]
    if (VIDEO_PROCESSING_SELECT && BUS_WIDTH_SELECT) begin
      next_mode = svip_pkg::SVIP_MODE_LUMA_WIDE; // [RULE1]
    end else if (VIDEO_PROCESSING_SELECT) begin
      next_mode = svip_pkg::SVIP_MODE_MUX_NARROW; // [RULE2]
    end else if (!BUS_WIDTH_SELECT && TRANSPORT_MODE_SELECT) begin
      next_mode = svip_pkg::SVIP_MODE_ASI; // [RULE4]
    end else begin
      next_mode = svip_pkg::SVIP_MODE_RAW; // [RULE3]
    end
  end

  always_comb begin
    next_luma = LUMA;
    next_chroma = CHROMA;
    next_raw = RAW;
    next_word_valid = 1'b0;
    next_asi_valid = 1'b0;
    unique case (mode)
      svip_pkg::SVIP_MODE_LUMA_WIDE: begin
        next_luma = hi_word; // [RULE1]
        next_chroma = din_s[`SVIP_WORD_W-1:0];
        next_word_valid = 1'b1;
      end
      svip_pkg::SVIP_MODE_MUX_NARROW: begin
        next_luma = dm_luma; // [RULE2]
        next_chroma = dm_chroma;
        next_word_valid = dm_valid;
      end
      svip_pkg::SVIP_MODE_ASI: begin
        next_raw = hi_word; // [RULE4]
        next_asi_valid = 1'b1;
      end
      default: begin
        next_raw = hi_word; // [RULE3]
        next_word_valid = 1'b1;
      end
    endcase
  end

  always_comb begin
    next_field2 = 1'b0;
    next_vblank = 1'b0;
    next_hblank = 1'b0;
    next_de = 1'b0;
    next_hsync = 1'b0;
    next_vsync = 1'b0;
    next_timing_valid = 1'b0;
    if (!STREAM_TIMING_DETECT) begin // [RULE10]
      next_timing_valid = 1'b1;
      if (SYNC_TIMING_FORM_SELECT) begin
        next_de = f_s; // [RULE6]
        next_hsync = h_s;
        next_vsync = v_s;
      end else begin
        next_field2 = f_s; // [RULE5]
        next_vblank = v_s; // [RULE11]
        next_hblank = h_s; // [RULE7] [RULE8] [RULE9]
        next_de = ~h_s & ~v_s;
      end
    end
  end

  always_comb begin
    if (mode == svip_pkg::SVIP_MODE_ASI) begin
      next_pclk = 18'(`SVIP_PCLK_ASI_KHZ); // [RULE12]
    end else if (BUS_WIDTH_SELECT) begin
      next_pclk = PROCESSING_FEATURES_ENABLE ? 18'(`SVIP_PCLK_HD_WIDE_KHZ)
        : 18'(`SVIP_PCLK_SD_WIDE_KHZ); // [RULE12]
    end else begin
      next_pclk = PROCESSING_FEATURES_ENABLE ? 18'(`SVIP_PCLK_HD_NARROW_KHZ)
        : 18'(`SVIP_PCLK_SD_NARROW_KHZ); // [RULE12]
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      mode <= svip_pkg::SVIP_MODE_RAW;
      mux_en <= 1'b0;
      MODE <= 3'h0;
      LUMA <= '0;
      CHROMA <= '0;
      RAW <= '0;
      WORD_VALID <= 1'b0;
      ASI_VALID <= 1'b0;
      FIELD2 <= 1'b0;
      VBLANK <= 1'b0;
      HBLANK <= 1'b0;
      DATA_ENABLE <= 1'b0;
      HSYNC <= 1'b0;
      VSYNC <= 1'b0;
      TIMING_VALID <= 1'b0;
      PCLK_KHZ <= '0;
    end else begin
      mode <= next_mode;
      mux_en <= next_mux_en;
      MODE <= mode;
      LUMA <= next_luma;
      CHROMA <= next_chroma;
      RAW <= next_raw;
      WORD_VALID <= next_word_valid;
      ASI_VALID <= next_asi_valid;
      FIELD2 <= next_field2;
      VBLANK <= next_vblank;
      HBLANK <= next_hblank;
      DATA_ENABLE <= next_de;
      HSYNC <= next_hsync;
      VSYNC <= next_vsync;
      TIMING_VALID <= next_timing_valid;
      PCLK_KHZ <= next_pclk;
    end
  end
endmodule

/* File: svip_properties.sv */
// Pin-level and output timing properties of the parallel video input port
`timescale 1ns/100ps
`include "svip_consts.svh"
module svip_properties (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [`SVIP_BUS_W-1:0] din,
  input wire logic field_or_enable_in,
  input wire logic vert_or_vsync,
  input wire logic horiz_or_hsync,
  input wire logic SYNC_FORM,
  input wire logic IN_HBLANK,
  input wire logic IN_VBLANK,
  input wire logic IN_FIELD2,
  input wire logic PROGRESSIVE,
  input wire logic BUS_WIDTH_SELECT,
  input wire logic VIDEO_PROCESSING_SELECT,
  input wire logic TRANSPORT_MODE_SELECT,
  input wire logic STREAM_TIMING_DETECT,
  input wire logic [2:0] MODE,
  input wire logic [`SVIP_WORD_W-1:0] LUMA,
  input wire logic [`SVIP_WORD_W-1:0] RAW,
  input wire logic WORD_VALID,
  input wire logic HBLANK,
  input wire logic VBLANK,
  input wire logic TIMING_VALID
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // Past reset term keeps the reset value of the source pins out of the check
  property p_flags;
    $past(RST_N && !SYNC_FORM) |-> horiz_or_hsync == $past(IN_HBLANK)
      && vert_or_vsync == $past(IN_VBLANK);
  endproperty
  a_flags: assert property (p_flags) else $error("flag pins off");
  property p_field;
    $past(RST_N && !SYNC_FORM) |-> field_or_enable_in == $past(IN_FIELD2 && !PROGRESSIVE);
  endproperty
  a_field: assert property (p_field) else $error("field pin off");
  property p_de;
    $past(RST_N && SYNC_FORM) |-> field_or_enable_in == $past(!IN_HBLANK && !IN_VBLANK);
  endproperty
  a_de: assert property (p_de) else $error("enable pin off");
  property p_ign;
    STREAM_TIMING_DETECT [*4] |-> !TIMING_VALID && !HBLANK && !VBLANK;
  endproperty
  a_ign: assert property (p_ign) else $error("timing not ignored");
  property p_samp;
    (!STREAM_TIMING_DETECT && !SYNC_FORM) [*4] |-> HBLANK == $past(horiz_or_hsync, 2)
      && VBLANK == $past(vert_or_vsync, 2);
  endproperty
  a_samp: assert property (p_samp) else $error("timing sample off");
  property p_wide;
    (BUS_WIDTH_SELECT && VIDEO_PROCESSING_SELECT) [*4] ##0 WORD_VALID
      |-> LUMA == $past(din[19:10], 2);
  endproperty
  a_wide: assert property (p_wide) else $error("wide luma off");
  property p_raw;
    (!VIDEO_PROCESSING_SELECT && !TRANSPORT_MODE_SELECT) [*4] ##0 WORD_VALID
      |-> RAW == $past(din[19:10], 2);
  endproperty
  a_raw: assert property (p_raw) else $error("raw word off");
  property p_asi;
    (!BUS_WIDTH_SELECT && !VIDEO_PROCESSING_SELECT && TRANSPORT_MODE_SELECT
      && !STREAM_TIMING_DETECT) [*4] |-> MODE == 3'h3;
  endproperty
  a_asi: assert property (p_asi) else $error("transport mode off");
  c_asi: cover property (MODE == 3'h3);
  c_mux: cover property (MODE == 3'h1 && WORD_VALID);
  c_tim: cover property (TIMING_VALID && !HBLANK);
endmodule

/* File: svip_source.sv */
// Upstream video source end: drives bus and timing pins from user requests
`timescale 1ns/100ps
`include "svip_consts.svh"
module svip_source (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  svip_if.source link,
  input wire logic BUS_WIDE,
  input wire logic SMPTE_ON,
  input wire logic ASI_ON,
  input wire logic SYNC_FORM,
  input wire logic H_TRS_FORM,
  input wire logic [`SVIP_WORD_W-1:0] Y_WORD,
  input wire logic [`SVIP_WORD_W-1:0] C_WORD,
  input wire logic [`SVIP_WORD_W-1:0] RAW_WORD,
  input wire logic IN_HBLANK,
  input wire logic IN_VBLANK,
  input wire logic IN_FIELD2,
  input wire logic PROGRESSIVE,
  input wire logic HSYNC_REQ,
  input wire logic VSYNC_REQ,
  output logic CHROMA_NEXT
);
  logic [`SVIP_BUS_W-1:0] next_din;
  logic next_f;
  logic next_v;
  logic next_h;
  logic phase;
  logic next_phase;
  logic [`SVIP_BUS_W-1:0] din_q;
  logic f_q;
  logic v_q;
  logic h_q;

  always_comb begin
    // Rest on chroma outside narrow video so the first narrow word is chroma
    next_phase = 1'b0; // [RULE2]
    next_din = '0;
    if (SMPTE_ON && BUS_WIDE) begin
      next_din = {Y_WORD, C_WORD}; // [RULE1]
    end else if (SMPTE_ON) begin
      next_din[`SVIP_BUS_W-1:`SVIP_HI_LSB] = phase ? Y_WORD : C_WORD; // [RULE2]
      next_phase = ~phase;
    end else begin
      next_din[`SVIP_BUS_W-1:`SVIP_HI_LSB] = RAW_WORD; // [RULE3] [RULE4]
    end
    if (SYNC_FORM) begin
      next_f = ~(IN_HBLANK | IN_VBLANK); // [RULE6]
      next_v = VSYNC_REQ;
      next_h = HSYNC_REQ;
    end else begin
      next_f = IN_FIELD2 & ~PROGRESSIVE; // [RULE5]
      next_v = IN_VBLANK; // [RULE11]
      // Both variants hold H high across blanking incl. TRS positions
      next_h = H_TRS_FORM ? IN_HBLANK : IN_HBLANK; // [RULE7] [RULE8] [RULE9]
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      phase <= 1'b0;
      din_q <= '0;
      f_q <= 1'b0;
      v_q <= 1'b0;
      h_q <= 1'b1;
      CHROMA_NEXT <= 1'b1;
    end else begin
      phase <= next_phase;
      din_q <= next_din;
      f_q <= next_f;
      v_q <= next_v;
      h_q <= next_h;
      CHROMA_NEXT <= ~next_phase;
    end
  end

  assign link.din = din_q;
  assign link.field_or_enable_in = f_q;
  assign link.vert_or_vsync = v_q;
  assign link.horiz_or_hsync = h_q;
endmodule
